// ---- dcpp_top.sv ----
// Downstream charge port power control with enable register
`timescale 1ns/100ps
`include "dcpp_defines.svh"
module dcpp_top
  import dcpp_pkg::*;
#(
  parameter int NUM_PORTS = 3
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial configuration register access
  input wire dcpp_cfg_req_t cfg_req,
  input wire logic cfg_load_done,
  output logic [7:0] cfg_rdata,
  // Hub logic per port
  input wire logic [NUM_PORTS-1:0] port_power_feature,
  input wire logic [NUM_PORTS-1:0] hub_power_request,
  // Port pins and charging handshake
  input wire logic [NUM_PORTS-1:0] overcurrent_sense_low,
  input wire logic [NUM_PORTS-1:0] charge_query,
  output logic [NUM_PORTS-1:0] port_power_output,
  output logic [NUM_PORTS-1:0] charge_ack,
  output logic [NUM_PORTS-1:0] overcurrent_latched,
  // Regulator control
  output logic main_3v3_regulator
);
  typedef struct packed {
    dcpp_phase_t phase;
    logic [7:0] charge_port_enable;
    logic [7:0] rdata;
  } dcpp_top_state_t;
  dcpp_top_state_t st;
  dcpp_top_state_t next_st;
  logic cfg_done;

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    unique case (st.phase)
      DCPP_CONFIG: begin
        // Writes take effect only while configuring, so port type cannot change later
        if (cfg_req.wr && cfg_req.addr == `DCPP_CHARGE_PORT_ENABLE_ADDR) begin
          next_st.charge_port_enable = cfg_req.wdata;
        end
        if (cfg_load_done) begin
          next_st.phase = DCPP_RUN;
        end
      end
      DCPP_RUN: begin
      end
      default: next_st.phase = DCPP_CONFIG;
    endcase
    if (cfg_req.rd && cfg_req.addr == `DCPP_CHARGE_PORT_ENABLE_ADDR) begin
      next_st.rdata = st.charge_port_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.phase <= DCPP_CONFIG;
      st.charge_port_enable <= `DCPP_CHARGE_PORT_ENABLE_RESET;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_done = (st.phase == DCPP_RUN);
  assign cfg_rdata = st.rdata;
  // Regulator follows the reset pin directly
  assign main_3v3_regulator = rst_n;

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    dcpp_port_ctrl u_port (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cfg_done(cfg_done),
      .charge_en(st.charge_port_enable[i + `DCPP_FIRST_PORT_BIT]),
      .port_power_feature(port_power_feature[i]),
      .hub_power_request(hub_power_request[i]),
      .overcurrent_sense_low(overcurrent_sense_low[i]),
      .charge_query(charge_query[i]),
      .port_power_output(port_power_output[i]),
      .charge_ack(charge_ack[i]),
      .overcurrent_latched(overcurrent_latched[i])
    );
  end

  a_type_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_done |=> $stable(st.charge_port_enable)) else $error("port type changed after configuration");
  a_config_stays: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_done |=> cfg_done) else $error("left run phase");
  a_reg_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!cfg_done && cfg_req.wr && cfg_req.addr == 8'hD0) |=> st.charge_port_enable == $past(cfg_req.wdata))
    else $error("enable write lost");
endmodule

// ---- dcpp_defines.svh ----
// Constants for the downstream charge port power block
`ifndef DCPP_DEFINES_SVH
`define DCPP_DEFINES_SVH
// How it works
// - Each downstream port individually charge-configurable
// - Charging port acknowledges device charging query
// - Never send negative answer; silence means no
// - Port type fixed after configuration completes
// - Charging logic drives charging port power
// - Power asserts once configuration done, held
// - Overcurrent drops power until chip reset
// - After enumeration hub logic owns power
// - Port power feature one: hub owns
// - Port power feature zero: charging logic owns
// - Overcurrent always drops power, any owner
// - Enable register at D0, bit1 is port1
// - Enable bit asserts that port's power
// - Reset input high turns regulator on
// - Reset input low turns regulator off
`define DCPP_CHARGE_PORT_ENABLE_ADDR 8'hD0
`define DCPP_CHARGE_PORT_ENABLE_RESET 8'h00
`define DCPP_FIRST_PORT_BIT 1
`endif

// ---- dcpp_pkg.sv ----
// Types for the downstream charge port power block
package dcpp_pkg;
  typedef enum logic [1:0] {DCPP_CONFIG, DCPP_RUN} dcpp_phase_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dcpp_cfg_req_t;
endpackage

// ---- dcpp_port_ctrl.sv ----
// One downstream port: ownership and overcurrent latch
`timescale 1ns/100ps
`include "dcpp_defines.svh"
module dcpp_port_ctrl
  import dcpp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic cfg_done,
  input wire logic charge_en,
  input wire logic port_power_feature,
  input wire logic hub_power_request,
  input wire logic overcurrent_sense_low,
  input wire logic charge_query,
  // Results
  output logic port_power_output,
  output logic charge_ack,
  output logic overcurrent_latched
);
  typedef struct packed {
    logic oc_meta;
    logic oc_sync;
    logic oc_lat;
    logic pwr;
    logic ack;
  } dcpp_port_state_t;
  dcpp_port_state_t st;
  dcpp_port_state_t next_st;

  always_comb begin
    next_st = st;
    // Second stage only feeds logic
    next_st.oc_meta = ~overcurrent_sense_low;
    next_st.oc_sync = st.oc_meta;
    // Latch holds until chip reset
    if (st.oc_sync) begin
      next_st.oc_lat = 1'b1;
    end
    if (st.oc_sync || st.oc_lat) begin
      next_st.pwr = 1'b0;
    end else if (port_power_feature) begin
      next_st.pwr = hub_power_request;
    end else if (charge_en && cfg_done) begin
      next_st.pwr = 1'b1;
    end else begin
      next_st.pwr = 1'b0;
    end
    // Only a positive answer exists; no answer otherwise
    next_st.ack = charge_query && charge_en && cfg_done;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port_power_output = st.pwr;
  assign charge_ack = st.ack;
  assign overcurrent_latched = st.oc_lat;

  a_oc_drops_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.oc_lat |=> !port_power_output) else $error("power on after overcurrent latch");
  a_oc_latch_sticks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.oc_lat |=> st.oc_lat) else $error("overcurrent latch released");
  a_hub_owns_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port_power_feature && !st.oc_sync && !st.oc_lat) |=> (port_power_output == $past(hub_power_request)))
    else $error("hub request not followed");
  a_charge_owns_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!port_power_feature && charge_en && cfg_done && !st.oc_sync && !st.oc_lat) |=> port_power_output)
    else $error("charging port not powered");
  a_no_negative_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !charge_en |=> !charge_ack) else $error("answer on standard port");
endmodule

// ---- dcpp_dev_model.sv ----
// Device-side model: charge queries and overcurrent pins of the ports
`timescale 1ns/100ps
module dcpp_dev_model
  import dcpp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Stimulus from the bench
  input wire logic [2:0] query_req,
  input wire logic [2:0] fault,
  // Hub side
  input wire logic [2:0] charge_ack,
  output logic [2:0] charge_query,
  output logic [2:0] overcurrent_sense_low,
  output logic [2:0] supported
);
  // Overcurrent pins idle high like a pulled-up line; query pins idle low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_query <= 3'h0;
      overcurrent_sense_low <= 3'h7;
      supported <= 3'h0;
    end else begin
      charge_query <= query_req;
      overcurrent_sense_low <= ~fault;
      supported <= supported | (charge_ack & charge_query);
    end
  end
endmodule

// ---- tb.sv ----
// Testbench for the downstream charge port power block
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module tb;
  import dcpp_pkg::*;
  logic sys_clk = 0, rst_n = 0, cfg_load_done = 0;
  dcpp_cfg_req_t cfg_req = '0;
  logic [2:0] port_power_feature = 0, hub_power_request = 0, query_req = 0, fault = 0;
  logic [2:0] overcurrent_sense_low, charge_query, port_power_output, charge_ack, overcurrent_latched, supported;
  logic [7:0] cfg_rdata;
  logic main_3v3_regulator;
  int num_errors = 0, n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  dcpp_top #(.NUM_PORTS(3)) i_dcpp_top (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_load_done(cfg_load_done), .cfg_rdata(cfg_rdata), .port_power_feature(port_power_feature),
    .hub_power_request(hub_power_request), .overcurrent_sense_low(overcurrent_sense_low),
    .charge_query(charge_query), .port_power_output(port_power_output), .charge_ack(charge_ack),
    .overcurrent_latched(overcurrent_latched), .main_3v3_regulator(main_3v3_regulator));
  dcpp_dev_model i_dcpp_dev_model (.sys_clk(sys_clk), .rst_n(rst_n), .query_req(query_req),
    .fault(fault), .charge_ack(charge_ack), .charge_query(charge_query),
    .overcurrent_sense_low(overcurrent_sense_low), .supported(supported));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) cfg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) cfg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) cfg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) cfg_req.rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    end_sim;
  end
  logic [7:0] d;
  initial begin
    cyc(10);
    `CHK("regulator in reset", 1'b0, main_3v3_regulator)
    `CHK("power in reset", 3'h0, port_power_output)
    @(posedge sys_clk) rst_n <= 1'b1;
    cyc(1);
    `CHK("regulator on", 1'b1, main_3v3_regulator)
    rd(8'hD0, d); `CHK("enable reset", 8'h00, d)
    wr(8'hD0, 8'h04);
    rd(8'hD0, d); `CHK("enable readback", 8'h04, d)
    rd(8'hD1, d); `CHK("unmapped read", 8'h00, d)
    cyc(2);
    `CHK("power before done", 3'h0, port_power_output)
    @(posedge sys_clk) cfg_load_done <= 1'b1;
    cyc(5);
    `CHK("power after config", 3'h2, port_power_output)
    $display("test config done");
    @(posedge sys_clk) query_req <= 3'h7;
    cyc(5);
    `CHK("charge ack", 3'h2, charge_ack)
    `CHK("device sees support", 3'h2, supported)
    wr(8'hD0, 8'hFF);
    rd(8'hD0, d); `CHK("frozen enable", 8'h04, d)
    cyc(3);
    `CHK("type fixed", 3'h2, port_power_output)
    $display("test query done");
    @(posedge sys_clk) port_power_feature <= 3'h3;
    hub_power_request <= 3'h1;
    cyc(3);
    `CHK("hub owns", 3'h1, port_power_output)
    @(posedge sys_clk) port_power_feature <= 3'h0;
    cyc(3);
    `CHK("charger owns", 3'h2, port_power_output)
    $display("test owner done");
    @(posedge sys_clk) fault <= 3'h2;
    cyc(2);
    `CHK("sync delay", 3'h2, port_power_output)
    cyc(4);
    `CHK("overcurrent cut", 3'h0, port_power_output)
    `CHK("overcurrent flag", 3'h2, overcurrent_latched)
    @(posedge sys_clk) fault <= 3'h0;
    port_power_feature <= 3'h2;
    hub_power_request <= 3'h2;
    cyc(5);
    `CHK("cut under hub", 3'h0, port_power_output)
    $display("test overcurrent done");
    end_sim;
  end
endmodule
